// >>> design/expander_pkg.sv
// Constants for the twelve-bit parallel-in serial-out expander.
// Assumes a single core clock; the link clock is a sampled input.
package expander_pkg;
	localparam int DATA_BITS = 12;
	localparam int EDGES_TO_IDLE = 13;
	localparam logic [3:0] CNT_RESET = 4'h0;
	localparam logic [11:0] SHIFT_RESET = 12'h000;
	localparam logic [1:0] SYNC_RESET = 2'h3;
	typedef enum logic [1:0] {st_idle, st_shift, st_unknown} mode_type;
endpackage

// >>> design/word_buffer.sv
// Two-entry valid/ready buffer for captured words.
// Assumes source and sink on the same clock.
`timescale 1ns/10ps
`default_nettype none
module word_buffer #(
	parameter int WIDTH = 12
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] mem_ff [2];
	logic rd_ff;
	logic wr_ff;
	logic [1:0] cnt_ff;
	logic push;
	logic pop;

	assign in_ready = (cnt_ff != 2'h2);
	assign out_valid = (cnt_ff != 2'h0);
	assign out_data = mem_ff[rd_ff];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_ff <= 2'h0;
			rd_ff <= 1'b0;
			wr_ff <= 1'b0;
		end else begin
			cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
			if (push) begin
				wr_ff <= ~wr_ff;
			end
			if (pop) begin
				rd_ff <= ~rd_ff;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_ff[wr_ff] <= in_data;
		end
	end
endmodule
`default_nettype wire

// >>> design/serial_expander.sv
// Device side of the twelve-bit parallel-in serial-out expander.
// Assumes the shift clock, shared line and parallel inputs are asynchronous pins.
// It also assumes a pull-up on the shared line, so a released line reads high.
`timescale 1ns/10ps
`default_nettype none
module serial_expander
	import expander_pkg::*;
#(
	parameter int BITS = DATA_BITS
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Link pins
	input wire logic shift_clk_n,
	input wire logic latch_and_serial_line_in,
	output logic latch_and_serial_line_out,
	output logic latch_and_serial_line_oe,
	// Parallel inputs
	input wire logic [BITS-1:0] parallel_inputs,
	// Captured word stream
	output logic word_valid,
	input wire logic word_ready,
	output logic [BITS-1:0] word_data
);
	logic [1:0] clk_sync_ff;
	logic [1:0] line_sync_ff;
	logic clk_prev_ff;
	logic line_prev_ff;
	logic [BITS-1:0] par_s1_ff;
	logic [BITS-1:0] par_s2_ff;
	logic [BITS-1:0] shift_ff;
	logic [3:0] edge_cnt_ff;
	mode_type mode_ff;
	logic out_ff;
	logic oe_ff;
	logic valid_ff;
	logic [BITS-1:0] data_ff;
	logic buf_valid;
	logic [BITS-1:0] buf_data;
	logic clk_fall;
	logic line_fall;
	logic capture;
	logic take_word;

	// The thirteenth fall ends a frame and the power-up sequence alike.
	function automatic logic is_last(input logic [3:0] cnt);
		return cnt == 4'(EDGES_TO_IDLE - 1);
	endfunction

	// The first fall shows the lowest bit without shifting.
	function automatic logic is_first(input logic [3:0] cnt);
		return cnt == CNT_RESET;
	endfunction

	// Link clock synchroniser; it resets to the idle high, so no false fall follows reset.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			clk_sync_ff <= SYNC_RESET;
			clk_prev_ff <= 1'b1;
		end else begin
			clk_sync_ff <= {clk_sync_ff[0], shift_clk_n};
			clk_prev_ff <= clk_sync_ff[1];
		end
	end

	// Shared line synchroniser; the pull-up makes high its idle level.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			line_sync_ff <= SYNC_RESET;
			line_prev_ff <= 1'b1;
		end else begin
			line_sync_ff <= {line_sync_ff[0], latch_and_serial_line_in};
			line_prev_ff <= line_sync_ff[1];
		end
	end

	// Two flops per input bit; the host holds the inputs steady around the start.
	always_ff @(posedge core_clk) begin
		par_s1_ff <= parallel_inputs;
		par_s2_ff <= par_s1_ff;
	end

	// One-cycle enables mark a fall of the synchronised clock and line.
	assign clk_fall = clk_prev_ff && !clk_sync_ff[1];
	assign line_fall = line_prev_ff && !line_sync_ff[1];
	// Capture takes the synchronised inputs, which trail the pins by two cycles.
	// Start condition check.
	assign capture = (mode_ff == st_idle) && line_fall && clk_sync_ff[1];

	// Mode stays unknown until the reset sequence, so an undefined power-up never drives the line.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			mode_ff <= st_unknown;
		end else begin
			case (mode_ff)
				st_idle: begin
					if (capture) begin
						mode_ff <= st_shift;
					end
				end
				st_shift, st_unknown: begin
					if (clk_fall && is_last(edge_cnt_ff)) begin
						mode_ff <= st_idle;
					end
				end
				default: begin
					// An illegal code falls back to the safe, non-driving mode.
					mode_ff <= st_unknown;
				end
			endcase
		end
	end

	// Falls count in the unknown mode too; that is what makes the reset sequence work.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			edge_cnt_ff <= CNT_RESET;
		end else if (mode_ff == st_idle) begin
			edge_cnt_ff <= CNT_RESET;
		end else if (clk_fall) begin
			if (is_last(edge_cnt_ff)) begin
				edge_cnt_ff <= CNT_RESET;
			end else begin
				edge_cnt_ff <= edge_cnt_ff + 4'h1;
			end
		end
	end

	// The captured word waits here; the first fall shows bit zero, later falls shift.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			shift_ff <= SHIFT_RESET;
		end else if (capture) begin
			shift_ff <= par_s2_ff;
		end else if (mode_ff == st_shift && clk_fall && !is_first(edge_cnt_ff)) begin
			shift_ff <= {1'b0, shift_ff[BITS-1:1]};
		end
	end

	// The enable is a register, so the pin never glitches into drive.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			oe_ff <= 1'b0;
		end else if (capture) begin
			oe_ff <= 1'b1;
		end else if (mode_ff != st_shift) begin
			oe_ff <= 1'b0;
		end else if (clk_fall && is_last(edge_cnt_ff)) begin
			oe_ff <= 1'b0;
		end
	end

	// Driven value; it rests high, so a stray enable can only show the idle level.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			out_ff <= 1'b1;
		end else if (capture) begin
			out_ff <= 1'b0;
		end else if (mode_ff != st_shift) begin
			out_ff <= 1'b1;
		end else if (clk_fall) begin
			if (is_last(edge_cnt_ff)) begin
				out_ff <= 1'b1;
			end else if (is_first(edge_cnt_ff)) begin
				out_ff <= shift_ff[0];
			end else begin
				out_ff <= shift_ff[1];
			end
		end
	end

	// The stage refills only when empty or taken, so a stalled word is never overwritten.
	assign take_word = word_ready || !valid_ff;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			valid_ff <= 1'b0;
			data_ff <= SHIFT_RESET;
		end else if (take_word) begin
			valid_ff <= buf_valid;
			data_ff <= buf_data;
		end
	end

	// A full buffer refuses the word; the serial side is never held up by it.
	word_buffer #(
		.WIDTH(BITS)
	) u_buf (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.in_valid(capture),
		.in_ready(),
		.in_data(par_s2_ff),
		.out_valid(buf_valid),
		.out_ready(take_word),
		.out_data(buf_data)
	);

	assign latch_and_serial_line_out = out_ff;
	assign latch_and_serial_line_oe = oe_ff;
	assign word_valid = valid_ff;
	assign word_data = data_ff;
endmodule
`default_nettype wire

// >>> verification/serial_expander_sva.sv
// Assertions on the expander link pins.
// Assumes link clock falls come at least eight core cycles apart.
`timescale 1ns/10ps
`default_nettype none
module serial_expander_sva (
	// Watched pins
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic shift_clk_n,
	input wire logic latch_and_serial_line_out,
	input wire logic latch_and_serial_line_oe
);
	logic oe, so, clk_ff;
	logic [3:0] frame_ff, boot_ff;
	assign oe = latch_and_serial_line_oe;
	assign so = latch_and_serial_line_out;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	// Raw pin falls are counted, so synchroniser delay only widens the windows.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			clk_ff <= 1'h1;
			frame_ff <= 4'h0;
			boot_ff <= 4'h0;
		end else begin
			clk_ff <= shift_clk_n;
			frame_ff <= oe ? frame_ff + 4'(clk_ff & !shift_clk_n) : 4'h0;
			if (clk_ff && !shift_clk_n && boot_ff != 4'hD) boot_ff <= boot_ff + 4'h1;
		end
	end
	a_capture_clk_high: assert property ($rose(oe) |-> shift_clk_n)
		else $error("ack with clock low");
	a_ack_low: assert property ($rose(oe) |-> !so)
		else $error("ack not low");
	a_bit_steady: assert property (shift_clk_n[*6] ##1 (oe && $past(oe)) |-> $stable(so))
		else $error("bit moved without clock fall");
	a_release_13th: assert property (frame_ff == 4'hD |-> ##[0:6] !oe)
		else $error("line held after last fall");
	a_boot_first: assert property ($rose(oe) |-> boot_ff == 4'hD)
		else $error("ack before boot falls");
	c_ack: cover property ($rose(oe));
	c_release: cover property ($fell(oe));
	c_boot: cover property (boot_ff == 4'hD && !oe);
endmodule
bind serial_expander serial_expander_sva chk (.core_clk, .reset_n, .shift_clk_n,
	.latch_and_serial_line_out, .latch_and_serial_line_oe);
`default_nettype wire

// >>> verification/host_model.sv
// Host model: pulls the shared line low and clocks out one word.
// Assumes each task starts on a falling core clock edge.
`timescale 1ns/10ps
`default_nettype none
module host_model (
	// Link pins
	output logic shift_clk_n,
	output logic host_oe,
	input wire logic latch_and_serial_line_in
);
	initial begin
		shift_clk_n = 1'h1;
		host_oe = 1'h0;
	end
	task automatic access(output logic [11:0] w, output logic ack);
		host_oe = 1'h1;
		#400 host_oe = 1'h0;
		#100 ack = latch_and_serial_line_in;
		for (int i = 0; i < 13; i++) begin
			#200 if (i > 0) w[i-1] = latch_and_serial_line_in;
			shift_clk_n = 1'h0;
			#200 shift_clk_n = 1'h1;
		end
		#400;
	endtask
endmodule
`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench: host model, expander and a queue of expected words.
// Assumes the host model starts each access on a falling core clock edge.
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic core_clk = 1'h0;
	logic reset_n = 1'h0;
	logic word_ready = 1'h1;
	logic [11:0] parallel_inputs = 12'h000;
	logic shift_clk_n, host_oe, latch_and_serial_line_in, latch_and_serial_line_out;
	logic latch_and_serial_line_oe, word_valid, ack;
	logic [11:0] word_data, got, d;
	logic [11:0] exp_q[$];
	int failures = 0;
	int tests_run = 0;
	always #25 core_clk = ~core_clk;
	// The pull-up holds the line high when nobody drives it.
	assign latch_and_serial_line_in = ~host_oe &
		(latch_and_serial_line_oe ? latch_and_serial_line_out : 1'h1);
	host_model host (
		.shift_clk_n(shift_clk_n),
		.host_oe(host_oe),
		.latch_and_serial_line_in(latch_and_serial_line_in)
	);
	serial_expander DUT (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.shift_clk_n(shift_clk_n),
		.latch_and_serial_line_in(latch_and_serial_line_in),
		.latch_and_serial_line_out(latch_and_serial_line_out),
		.latch_and_serial_line_oe(latch_and_serial_line_oe),
		.parallel_inputs(parallel_inputs),
		.word_valid(word_valid),
		.word_ready(word_ready),
		.word_data(word_data)
	);
	task automatic check(input logic [11:0] g, input logic [11:0] e);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("wrong value at %0t: %h not %h", $time, g, e);
		end
	endtask
	task automatic close_out;
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// The output stage and two buffer entries hold three words; a fourth is dropped.
	task automatic read_one(input logic acked);
		d = 12'($urandom);
		parallel_inputs = d;
		#200;
		if (acked && exp_q.size() < 3) exp_q.push_back(d);
		fork
			host.access(got, ack);
			#1200 parallel_inputs = ~d;
		join
		check({11'h0, ack}, {11'h0, !acked});
		if (acked) check(got, d);
		$display("access %h done", d);
	endtask
	always @(posedge core_clk) begin
		if (word_valid === 1'h1 && word_ready) begin
			if (exp_q.size() == 0) begin
				failures++;
				$display("wrong value at %0t: word %h not expected", $time, word_data);
			end else begin
				check(word_data, exp_q.pop_front());
			end
		end
	end
	initial begin
		void'($urandom(32'hd690));
		repeat (3) @(negedge core_clk);
		reset_n = 1'h1;
		read_one(1'h0);
		repeat (2) read_one(1'h1);
		word_ready = 1'h0;
		repeat (4) read_one(1'h1);
		word_ready = 1'h1;
		for (int i = 0; i < 40 && exp_q.size() > 0; i++) @(negedge core_clk);
		check(12'(exp_q.size()), 12'h000);
		close_out;
	end
endmodule
`default_nettype wire
